// [core/level_det_pkg.sv]
// constants, register map and state type for the input b level detector
package level_det_pkg;

  // ==========================================================================
  // widths
  localparam int SAMPLE_W = 14;
  localparam int MANT_W = 10;
  localparam int DWELL_W = 20;
  localparam int CTRL_W = 5;
  localparam int HOLD_W = 3;
  localparam int MAX_HOLD = 7;
  localparam int EXT_ADDR_W = 3;
  localparam int DATA_W = 20;
  localparam int BYTE_W = 8;

  // ==========================================================================
  // external microport addresses
  localparam logic [EXT_ADDR_W-1:0] EXT_SLEEP = 3'h3;
  localparam logic [EXT_ADDR_W-1:0] EXT_STATUS = 3'h5;
  localparam logic [EXT_ADDR_W-1:0] EXT_POINTER = 3'h6;
  localparam logic [EXT_ADDR_W-1:0] EXT_DATA = 3'h7;
  localparam int SLEEP_ACCESS_BIT = 5;

  // ==========================================================================
  // channel addresses of the input port b registers
  localparam logic [BYTE_W-1:0] CH_LOWER_B = 8'h04;
  localparam logic [BYTE_W-1:0] CH_UPPER_B = 8'h05;
  localparam logic [BYTE_W-1:0] CH_DWELL_B = 8'h06;
  localparam logic [BYTE_W-1:0] CH_CTRL_B = 8'h07;

  // ==========================================================================
  // gain range control fields
  localparam int POL_BIT = 4;
  localparam int ILV_BIT = 3;
  localparam int HOLD_LSB = 0;

  // ==========================================================================
  // values after reset
  localparam logic [BYTE_W-1:0] RST_SLEEP = 8'h00;
  localparam logic [BYTE_W-1:0] RST_POINTER = 8'h00;
  localparam logic [MANT_W-1:0] RST_LOWER = 10'h000;
  localparam logic [MANT_W-1:0] RST_UPPER = 10'h3FF;
  localparam logic [DWELL_W-1:0] RST_DWELL = 20'h00000;
  localparam logic [CTRL_W-1:0] RST_CTRL = 5'h00;

  // ==========================================================================
  // detector states
  typedef enum logic [1:0] {
    DET_IDLE,
    DET_ACTIVE,
    DET_DWELL
  } det_state_e;

endpackage : level_det_pkg

// [core/latency_if.sv]
// carrier between the detector and its programmable latency line
`timescale 1ns/10ps
`default_nettype none
interface latency_if;
  import level_det_pkg::*;
  logic level_in;
  logic [HOLD_W-1:0] hold_sel;
  logic level_out;
  modport src (output level_in, output hold_sel, input level_out);
  modport line (input level_in, input hold_sel, output level_out);
endinterface : latency_if
`default_nettype wire

// [core/latency_line.sv]
// programmable delay of the level indicator, zero to seven sample clocks
`timescale 1ns/10ps
`default_nettype none
module latency_line
  import level_det_pkg::*;
#(
  parameter int DEPTH = MAX_HOLD
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // delay taps
  latency_if.line lat
);

  logic [DEPTH-1:0] taps_r;

  // ==========================================================================
  // shift register runs always, so a change of tap takes effect at once
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      taps_r <= '0;
    end else begin
      taps_r <= {taps_r[DEPTH-2:0], lat.level_in};
    end
  end

  // tap zero is the undelayed level, each step one clock more
  always_comb begin
    if (lat.hold_sel == '0) begin
      lat.level_out = lat.level_in;
    end else begin
      lat.level_out = taps_r[HOLD_W'(lat.hold_sel - 3'h1)];
    end
  end

  // ==========================================================================
  // checks
  tap_two_delay_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (lat.hold_sel == 3'h2) [*3] |-> (lat.level_out == $past(lat.level_in, 2)))
    else $error("latency of two clocks not honoured");

  tap_one_delay_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (lat.hold_sel == 3'h1) [*2] |-> (lat.level_out == $past(lat.level_in)))
    else $error("latency of one clock not honoured");

endmodule : latency_line
`default_nettype wire

// [core/level_detector_b.sv]
// input port b level detector with dwell release and indicator pins
`timescale 1ns/10ps
`default_nettype none
module level_detector_b
  import level_det_pkg::*;
#(
  parameter int SAMPLE_WIDTH = SAMPLE_W
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // microport, synchronous to clk_i
  input wire logic [EXT_ADDR_W-1:0] ext_addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [DATA_W-1:0] rdata_o,
  // converter input pins
  input wire logic [SAMPLE_WIDTH-1:0] sample_i,
  input wire logic input_b_select_i,
  // level indicator pins
  output logic level_flag_b_primary_o,
  output logic level_flag_b_secondary_o
);

  // ==========================================================================
  // declarations
  logic [BYTE_W-1:0] sleep_r;
  logic [BYTE_W-1:0] channel_addr_pointer_r;
  logic [MANT_W-1:0] lower_r;
  logic [MANT_W-1:0] upper_r;
  logic [DWELL_W-1:0] dwell_r;
  logic [CTRL_W-1:0] ctrl_r;
  logic [SAMPLE_WIDTH-1:0] sample_meta_r;
  logic [SAMPLE_WIDTH-1:0] sample_sync_r;
  logic select_meta_r;
  logic select_sync_r;
  logic [DWELL_W-1:0] cnt_r;
  det_state_e det_state_r;
  logic [MANT_W-1:0] mant;
  logic upper_met;
  logic lower_met;
  logic det_enabled;
  logic access_en;
  logic polarity;
  logic interleave;
  logic level_delayed;
  logic primary_nxt;
  logic secondary_nxt;
  logic [DATA_W-1:0] rdata_nxt;

  latency_if lat ();

  // ==========================================================================
  // pin synchronisers, two flops before any logic
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sample_meta_r <= '0;
      sample_sync_r <= '0;
    end else begin
      sample_meta_r <= sample_i;
      sample_sync_r <= sample_meta_r;
    end
  end

  // the select pin travels the same depth as the samples it qualifies
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      select_meta_r <= 1'b0;
      select_sync_r <= 1'b0;
    end else begin
      select_meta_r <= input_b_select_i;
      select_sync_r <= select_meta_r;
    end
  end

  // ==========================================================================
  // register writes through the channel address pointer
  assign access_en = sleep_r[SLEEP_ACCESS_BIT];

  // sleep and pointer are always writable
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sleep_r <= RST_SLEEP;
      channel_addr_pointer_r <= RST_POINTER;
    end else if (wr_i) begin
      if (ext_addr_i == EXT_SLEEP) begin
        sleep_r <= wdata_i[BYTE_W-1:0];
      end
      if (ext_addr_i == EXT_POINTER) begin
        channel_addr_pointer_r <= wdata_i[BYTE_W-1:0];
      end
    end
  end

  // data window only lands while the access bit is set
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      lower_r <= RST_LOWER;
      upper_r <= RST_UPPER;
      dwell_r <= RST_DWELL;
      ctrl_r <= RST_CTRL;
    end else if (wr_i && ext_addr_i == EXT_DATA && access_en) begin
      unique case (channel_addr_pointer_r)
        CH_LOWER_B: lower_r <= wdata_i[MANT_W-1:0];
        CH_UPPER_B: upper_r <= wdata_i[MANT_W-1:0];
        CH_DWELL_B: dwell_r <= wdata_i[DWELL_W-1:0];
        CH_CTRL_B: ctrl_r <= wdata_i[CTRL_W-1:0];
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // register reads, unmapped locations answer zero
  always_comb begin
    rdata_nxt = '0;
    unique case (ext_addr_i)
      EXT_SLEEP: rdata_nxt[BYTE_W-1:0] = sleep_r;
      EXT_POINTER: rdata_nxt[BYTE_W-1:0] = channel_addr_pointer_r;
      EXT_STATUS: begin
        rdata_nxt[0] = (det_state_r != DET_IDLE);
        rdata_nxt[1] = (det_state_r == DET_DWELL);
        rdata_nxt[2] = level_flag_b_primary_o;
        rdata_nxt[3] = level_flag_b_secondary_o;
      end
      EXT_DATA: begin
        if (access_en) begin
          unique case (channel_addr_pointer_r)
            CH_LOWER_B: rdata_nxt[MANT_W-1:0] = lower_r;
            CH_UPPER_B: rdata_nxt[MANT_W-1:0] = upper_r;
            CH_DWELL_B: rdata_nxt = dwell_r;
            CH_CTRL_B: rdata_nxt[CTRL_W-1:0] = ctrl_r;
            default: rdata_nxt = '0;
          endcase
        end
      end
      default: rdata_nxt = '0;
    endcase
  end

  // read data holds until the next read strobe
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_o <= '0;
    end else if (rd_i) begin
      rdata_o <= rdata_nxt;
    end
  end

  // ==========================================================================
  // threshold compare on the ten mantissa msbs
  assign mant = sample_sync_r[SAMPLE_WIDTH-1 -: MANT_W];
  assign upper_met = (mant >= upper_r);
  assign lower_met = (mant <= lower_r);
  assign det_enabled = (dwell_r != '0);

  // ==========================================================================
  // detector state machine
  // idle waits for the upper excursion; active and dwell share the release
  // path so that a single sample at or below lower can count from either
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      det_state_r <= DET_IDLE;
    end else if (!det_enabled) begin
      det_state_r <= DET_IDLE;
    end else begin
      unique case (det_state_r)
        DET_IDLE: begin
          if (upper_met) begin
            det_state_r <= DET_ACTIVE;
          end
        end
        DET_ACTIVE, DET_DWELL: begin
          if (!lower_met) begin
            det_state_r <= DET_ACTIVE;
          end else if (cnt_r <= 20'h00001) begin
            det_state_r <= DET_IDLE;
          end else begin
            det_state_r <= DET_DWELL;
          end
        end
        default: det_state_r <= DET_IDLE; // unused code falls back to idle
      endcase
    end
  end

  // dwell down-counter, reloaded whenever not counting
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_r <= '0;
    end else if (det_state_r == DET_IDLE || !lower_met || !det_enabled) begin
      cnt_r <= dwell_r;
    end else if (cnt_r > 20'h00001) begin
      cnt_r <= cnt_r - 20'h00001;
    end else begin
      cnt_r <= dwell_r;
    end
  end

  // ==========================================================================
  // latency line, the pins follow the delayed level
  assign lat.level_in = (det_state_r != DET_IDLE);
  assign lat.hold_sel = ctrl_r[HOLD_LSB +: HOLD_W];
  assign level_delayed = lat.level_out;

  latency_line #(
    .DEPTH(MAX_HOLD)
  ) u_latency (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .lat(lat.line)
  );

  // ==========================================================================
  // pin steering and polarity
  assign polarity = ctrl_r[POL_BIT];
  assign interleave = ctrl_r[ILV_BIT];

  always_comb begin
    if (interleave) begin
      primary_nxt = polarity ^ (level_delayed & ~select_sync_r);
      secondary_nxt = polarity ^ (level_delayed & select_sync_r);
    end else begin
      primary_nxt = polarity ^ level_delayed;
      secondary_nxt = ~(polarity ^ level_delayed);
    end
  end

  // pins straight from flops; polarity inverts the active level
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      level_flag_b_primary_o <= 1'b0;
      level_flag_b_secondary_o <= 1'b1;
    end else begin
      level_flag_b_primary_o <= primary_nxt;
      level_flag_b_secondary_o <= secondary_nxt;
    end
  end

  // ==========================================================================
  // checks
  sequence s_last_low;
    (det_state_r == DET_DWELL) && lower_met && det_enabled && (cnt_r == 20'h00001);
  endsequence

  sequence s_rise_above;
    (det_state_r != DET_IDLE) && !lower_met && det_enabled;
  endsequence

  dwell_zero_off_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    !det_enabled |=> (det_state_r == DET_IDLE))
    else $error("detector ran with zero dwell");

  upper_activates_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (det_state_r == DET_IDLE) && det_enabled && upper_met |=> (det_state_r == DET_ACTIVE))
    else $error("upper threshold did not activate");

  dwell_release_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    s_last_low |=> (det_state_r == DET_IDLE))
    else $error("indicator not released after dwell");

  hold_while_count_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (det_state_r == DET_DWELL) && (cnt_r > 20'h00001) |=> (det_state_r != DET_IDLE))
    else $error("indicator released early");

  counter_reload_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    s_rise_above |=> (cnt_r == $past(dwell_r)) && (det_state_r == DET_ACTIVE))
    else $error("counter not reloaded on rise");

  counter_step_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (det_state_r != DET_IDLE) && lower_met && det_enabled && (cnt_r > 20'h00001)
    |=> (cnt_r == $past(cnt_r) - 20'h00001) && (det_state_r == DET_DWELL))
    else $error("dwell counter did not step");

  single_complement_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    !interleave |=> (level_flag_b_secondary_o == !level_flag_b_primary_o))
    else $error("secondary not complement in single mode");

  dual_route_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    interleave && select_sync_r
    |=> (level_flag_b_primary_o == $past(polarity))
     && (level_flag_b_secondary_o == ($past(polarity) ^ $past(level_delayed))))
    else $error("dual mode routing wrong");

  polarity_level_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    !interleave && (ctrl_r[HOLD_LSB +: HOLD_W] == 3'h0) && (det_state_r != DET_IDLE)
    |=> (level_flag_b_primary_o == !$past(polarity)))
    else $error("active level has wrong polarity");

endmodule : level_detector_b
`default_nettype wire

// [tb/gain_stage_model.sv]
// attenuator model ahead of the converter, steered by the primary indicator
`timescale 1ns/10ps
`default_nettype none
module gain_stage_model
  import level_det_pkg::*;
#(
  parameter int SETTLE = 2
) (
  // clock
  input wire logic clk_i,
  // indicator side
  input wire logic flag_i,
  input wire logic pol_i,
  // analog side in, converter codes out
  input wire logic [SAMPLE_W-1:0] raw_i,
  output logic [SAMPLE_W-1:0] sample_o
);
  // ==========================================================================
  // gain step settles a few clocks after the pin moves, never at once
  logic [SETTLE-1:0] eng_r = '0;
  always_ff @(posedge clk_i) begin
    eng_r <= {eng_r[SETTLE-2:0], flag_i ^ pol_i};
  end
  // 6 dB pad halves the code seen by the converter
  assign sample_o = eng_r[SETTLE-1] ? {1'b0, raw_i[SAMPLE_W-1:1]} : raw_i;
endmodule : gain_stage_model
`default_nettype wire

// [tb/level_detector_b_tb.sv]
// self-checking bench for the input b level detector
`timescale 1ns/10ps
`default_nettype none
module level_detector_b_tb;
  import level_det_pkg::*;
  typedef struct {logic [DATA_W-1:0] val; int cyc;} note_s;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [EXT_ADDR_W-1:0] ext_addr_i = '0;
  logic [DATA_W-1:0] wdata_i = '0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic input_b_select_i = 1'b0;
  logic pol = 1'b0;
  logic [SAMPLE_W-1:0] raw = '0;
  logic [SAMPLE_W-1:0] sample_i;
  logic [DATA_W-1:0] rdata_o;
  logic level_flag_b_primary_o;
  logic level_flag_b_secondary_o;
  logic rd_q = 1'b0;
  logic rd_qq = 1'b0;
  logic [1:0] pins_seen = 2'b01;
  logic [1:0] pins_exp = 2'b01;
  int failures = 0;
  int num_checks = 0;
  int cyc = 0;
  note_s rq[$];
  note_s pq[$];
  note_s n;

  // ==========================================================================
  // clock, device and far side
  always #50 clk_i = ~clk_i;
  level_detector_b level_detector_b_inst (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .ext_addr_i(ext_addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .sample_i(sample_i),
    .input_b_select_i(input_b_select_i), .level_flag_b_primary_o(level_flag_b_primary_o),
    .level_flag_b_secondary_o(level_flag_b_secondary_o));
  gain_stage_model gain_stage_model_inst (.clk_i(clk_i), .flag_i(level_flag_b_primary_o),
    .pol_i(pol), .raw_i(raw), .sample_o(sample_i));

  // ==========================================================================
  // helpers
  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic finish_test();
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test
  task automatic tick();
    @(posedge clk_i);
    #1;
  endtask : tick
  // strobe stays high across back-to-back writes; callers drop it
  task automatic wr(input logic [EXT_ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    ext_addr_i = a;
    wdata_i = d;
    wr_i = 1'b1;
    tick();
  endtask : wr
  task automatic rd(input logic [EXT_ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    ext_addr_i = a;
    rd_i = 1'b1;
    rq.push_back('{exp, cyc + 2});
    tick();
    rd_i = 1'b0;
    tick();
  endtask : rd
  task automatic chw(input logic [BYTE_W-1:0] ch, input logic [DATA_W-1:0] d);
    wr(EXT_SLEEP, DATA_W'(1) << SLEEP_ACCESS_BIT);
    wr(EXT_POINTER, DATA_W'(ch));
    wr(EXT_DATA, d);
    wr_i = 1'b0;
    tick();
  endtask : chw
  task automatic chr(input logic [BYTE_W-1:0] ch, input logic [DATA_W-1:0] exp);
    wr(EXT_SLEEP, DATA_W'(1) << SLEEP_ACCESS_BIT);
    wr(EXT_POINTER, DATA_W'(ch));
    wr_i = 1'b0;
    rd(EXT_DATA, exp);
  endtask : chr
  task automatic put(input logic [MANT_W-1:0] m);
    raw = {m, 4'($urandom)};
    tick();
  endtask : put
  function automatic logic [1:0] pins(input logic act, input logic [CTRL_W-1:0] c,
                                      input logic sel);
    logic p;
    p = c[POL_BIT] ^ (act & ~(c[ILV_BIT] & sel));
    return {p, c[ILV_BIT] ? (c[POL_BIT] ^ (act & sel)) : ~p};
  endfunction : pins
  // a negative cycle means the moment is not checked
  task automatic want(input logic [1:0] v, input int at);
    if (v !== pins_exp) begin
      pq.push_back('{DATA_W'(v), at});
      pins_exp = v;
    end
  endtask : want

  // one detection episode with a reload in the middle of the dwell
  task automatic run(input logic [2:0] lat, input logic pv, input logic ilv,
                     input logic sel, input int dw, input logic edge_v);
    logic [CTRL_W-1:0] c;
    logic [MANT_W-1:0] lo;
    c = {pv, ilv, lat};
    lo = edge_v ? 10'd10 : MANT_W'($urandom_range(10, 0));
    input_b_select_i = sel;
    pol = pv;
    want(pins(1'b0, c, sel), -1);
    chw(CH_CTRL_B, DATA_W'(c));
    chw(CH_DWELL_B, DATA_W'(dw));
    repeat (4) put(lo);
    want(pins(1'b1, c, sel), cyc + 4 + lat);
    put(edge_v ? 10'd500 : MANT_W'($urandom_range(1023, 500)));
    repeat (dw - 1) put(lo);
    put(MANT_W'($urandom_range(499, 22)));
    repeat (dw - 1) put(lo);
    want(pins(1'b0, c, sel), cyc + 4 + lat);
    repeat (13) put(lo);
    check(DATA_W'(pq.size()), '0);
    chw(CH_DWELL_B, '0);
    $display("test run done lat=%0d pol=%0d ilv=%0d", lat, pv, ilv);
  endtask : run

  // ==========================================================================
  // watcher: read data and every pin change against the oldest note
  always @(posedge clk_i) begin
    rd_q <= rd_i;
    rd_qq <= rd_q;
    cyc <= cyc + 1;
    if (cyc > 3000) begin
      failures++;
      finish_test();
    end
  end
  always @(posedge clk_i) begin
    #2;
    if (reset_n_i && rd_qq) begin
      n = rq.pop_front();
      check(rdata_o, n.val);
    end
    if (reset_n_i && {level_flag_b_primary_o, level_flag_b_secondary_o} !== pins_seen) begin
      pins_seen = {level_flag_b_primary_o, level_flag_b_secondary_o};
      n = (pq.size() > 0) ? pq.pop_front() : note_s'{20'hFFFFF, -1};
      check(DATA_W'(pins_seen), n.val);
      if (n.cyc >= 0) check(DATA_W'(cyc), DATA_W'(n.cyc));
    end
  end

  // ==========================================================================
  // main sequence
  initial begin
    void'($urandom(32'hB85DEDBE));
    repeat (16) @(posedge clk_i);
    #1;
    reset_n_i = 1'b1;
    tick();
    check(DATA_W'({level_flag_b_primary_o, level_flag_b_secondary_o}), 20'h00001);
    // data window is shut while the access bit is clear
    wr(EXT_POINTER, DATA_W'(CH_DWELL_B));
    wr(EXT_DATA, 20'h12345);
    wr_i = 1'b0;
    tick();
    chr(CH_DWELL_B, RST_DWELL);
    chr(CH_CTRL_B, RST_CTRL);
    chr(CH_UPPER_B, DATA_W'(RST_UPPER));
    chr(CH_LOWER_B, DATA_W'(RST_LOWER));
    chw(8'h08, 20'h0000F);
    chr(8'h08, '0);
    chw(CH_DWELL_B, 20'hFFFFF);
    chr(CH_DWELL_B, 20'hFFFFF);
    chw(CH_UPPER_B, 20'd500);
    chw(CH_LOWER_B, 20'd10);
    chr(CH_UPPER_B, 20'd500);
    chr(CH_LOWER_B, 20'd10);
    chw(CH_DWELL_B, '0);
    rd(3'h0, '0);
    rd(EXT_SLEEP, DATA_W'(1) << SLEEP_ACCESS_BIT);
    rd(EXT_POINTER, DATA_W'(CH_DWELL_B));
    rd(EXT_STATUS, 20'h00008);
    $display("test registers done");
    // zero dwell: a full-scale burst must not move the pins
    repeat (3) put(10'h3FF);
    repeat (12) put(10'h000);
    check(DATA_W'(pq.size()), '0);
    check(DATA_W'({level_flag_b_primary_o, level_flag_b_secondary_o}), 20'h00001);
    $display("test disabled done");
    run(3'd0, 1'b0, 1'b0, 1'b0, 1, 1'b1);
    run(3'd3, 1'b1, 1'b0, 1'b0, 3, 1'b0);
    run(3'd7, 1'b0, 1'b1, 1'b1, 2, 1'b0);
    run(3'd5, 1'b1, 1'b1, 1'b0, 4, 1'b0);
    run(3'd1, 1'b1, 1'b0, 1'b0, 2, 1'b1);
    run(3'd2, 1'b0, 1'b1, 1'b0, 3, 1'b0);
    finish_test();
  end
endmodule : level_detector_b_tb
`default_nettype wire
